// >>> iap_pkg.sv
// package: register map, fields, timing and modes of the flash page writer
package iap_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL0_OFFSET      = 8'h00;
  localparam logic [7:0] CTRL2_OFFSET      = 8'h04;
  localparam logic [7:0] ADDR_LOW_OFFSET   = 8'h08;
  localparam logic [7:0] ADDR_HIGH_OFFSET  = 8'h0C;
  localparam logic [7:0] DATA0_LOW_OFFSET  = 8'h10;
  localparam logic [7:0] DATA0_HIGH_OFFSET = 8'h14;
  localparam logic [7:0] UNLOCK_OFFSET     = 8'h18;

  // ----------------------------------------------------------------
  // control register 0 fields
  // ----------------------------------------------------------------
  localparam int CTRL0_EWEN_BIT  = 7;
  localparam int CTRL0_MODE_LSB  = 4;
  localparam int CTRL0_WSTART_BIT = 2;
  localparam int CTRL0_RDEN_BIT  = 1;
  localparam int CTRL0_RSTART_BIT = 0;

  // ----------------------------------------------------------------
  // control register 2 fields
  // ----------------------------------------------------------------
  localparam int CTRL2_TSEL_BIT  = 1;
  localparam int CTRL2_CLEAR_BIT = 0;

  // ----------------------------------------------------------------
  // operation select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_WRITE  = 3'h0;
  localparam logic [2:0] MODE_ERASE  = 3'h1;
  localparam logic [2:0] MODE_READ   = 3'h3;
  localparam logic [2:0] MODE_ENABLE = 3'h6;

  // ----------------------------------------------------------------
  // geometry and reset values
  // ----------------------------------------------------------------
  localparam int PAGE_WORDS = 64;
  localparam int WORD_BITS  = 6;
  localparam int PAGE_BITS  = 9;
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [15:0] WORD_ERASED = 16'hFFFF;
  localparam logic [5:0]  LAST_WORD   = 6'h3F;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int ERASE_T0_US   = 3200;
  localparam int WRITE_T0_US   = 2200;
  localparam int ERASE_T1_US   = 3700;
  localparam int WRITE_T1_US   = 3000;
  localparam int ERASE_T0_CYC  = ERASE_T0_US * CLK_MHZ;
  localparam int WRITE_T0_CYC  = WRITE_T0_US * CLK_MHZ;
  localparam int ERASE_T1_CYC  = ERASE_T1_US * CLK_MHZ;
  localparam int WRITE_T1_CYC  = WRITE_T1_US * CLK_MHZ;
  localparam int READ_CYC      = 2;
  localparam int TIMER_BITS    = 20;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CLEAR,
    ST_ERASE,
    ST_WRITE,
    ST_READ_REQ,
    ST_READ_WAIT
  } state_type;

endpackage

// >>> flash_port_if.sv
// interface: word port between the sequencer and the page buffer
`timescale 1ns/1ps
interface flash_port_if;
  logic        load;
  logic [5:0]  load_index;
  logic [15:0] load_word;
  logic        clear;
  logic [5:0]  rd_index;
  logic [15:0] rd_word;

  modport ctrl (output load, output load_index, output load_word, output clear, output rd_index, input rd_word);
  modport buf_side (input load, input load_index, input load_word, input clear, input rd_index, output rd_word);
endinterface

// >>> page_write_buffer.sv
// module: 64-word page write buffer with bulk clear
`timescale 1ns/1ps
module page_write_buffer #(
  parameter int DEPTH = 64
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  wire logic   clk_en,
  flash_port_if.buf_side port
);

  logic [15:0] mem_q [DEPTH];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // clear fills with erased value so unloaded words program as blank
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= iap_pkg::WORD_ERASED;
    end else if (clk_en) begin
      if (port.clear) begin
        for (int i = 0; i < DEPTH; i++) mem_q[i] <= iap_pkg::WORD_ERASED;
      end else if (port.load) begin
        mem_q[port.load_index] <= port.load_word;
      end
    end
  end

  assign port.rd_word = mem_q[port.rd_index];

endmodule // page_write_buffer

// >>> iap_flash_page_writer.sv
// module: apb in-application flash programming sequencer
`timescale 1ns/1ps

module iap_flash_page_writer #(
  parameter int ERASE_T0_CYC = iap_pkg::ERASE_T0_CYC,
  parameter int WRITE_T0_CYC = iap_pkg::WRITE_T0_CYC,
  parameter int ERASE_T1_CYC = iap_pkg::ERASE_T1_CYC,
  parameter int WRITE_T1_CYC = iap_pkg::WRITE_T1_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  output logic             cpu_stall,
  output logic             flash_erase,
  output logic             flash_write,
  output logic             flash_read,
  output logic [8:0]       flash_page,
  output logic [5:0]       flash_word,
  output logic [15:0]      flash_wdata,
  input  wire logic [15:0] flash_rdata,
  input  wire logic        unlock_ok
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    iap_pkg::state_type st;
    logic               ewen;
    logic [2:0]         mode;
    logic               wstart;
    logic               rden;
    logic               rstart;
    logic               tsel;
    logic               clr;
    logic [7:0]         addr_lo;
    logic [6:0]         addr_hi;
    logic [7:0]         data_lo;
    logic [7:0]         data_hi;
    logic [iap_pkg::TIMER_BITS-1:0] timer;
    logic [5:0]         idx;
    logic               erase_o;
    logic               write_o;
    logic               read_o;
    logic [31:0]        rdata;
  } regs_type;

  regs_type    r_q;
  regs_type    r_d;
  flash_port_if bport();

  page_write_buffer #(
    .DEPTH (iap_pkg::PAGE_WORDS)
  ) u_buf (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .port    (bport.buf_side)
  );

  logic       wr_acc;
  logic       rd_acc;
  logic [7:0] wbyte;
  logic       busy;
  logic [iap_pkg::TIMER_BITS-1:0] erase_cyc;
  logic [iap_pkg::TIMER_BITS-1:0] write_cyc;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign wbyte  = pwdata[7:0];
  assign busy   = (r_q.st != iap_pkg::ST_IDLE);

  // ----------------------------------------------------------------
  // timing selection
  // ----------------------------------------------------------------
  assign erase_cyc = r_q.tsel ? iap_pkg::TIMER_BITS'(ERASE_T1_CYC) : iap_pkg::TIMER_BITS'(ERASE_T0_CYC);
  assign write_cyc = r_q.tsel ? iap_pkg::TIMER_BITS'(WRITE_T1_CYC) : iap_pkg::TIMER_BITS'(WRITE_T0_CYC);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d             = r_q;
    bport.load      = 1'b0;
    bport.load_index = r_q.addr_lo[5:0];
    bport.load_word = {wbyte, r_q.data_lo};
    bport.clear     = 1'b0;
    bport.rd_index  = r_q.idx;
    r_d.rdata       = 32'h0000_0000;

    // register writes; config is frozen while an operation runs
    if (wr_acc && !busy) begin
      unique case (paddr)
        iap_pkg::CTRL0_OFFSET: begin
          if (!wbyte[iap_pkg::CTRL0_EWEN_BIT]) begin
            r_d.ewen = 1'b0;
          end
          r_d.mode   = wbyte[iap_pkg::CTRL0_MODE_LSB +: 3];
          r_d.rden   = wbyte[iap_pkg::CTRL0_RDEN_BIT];
          r_d.wstart = wbyte[iap_pkg::CTRL0_WSTART_BIT];
          r_d.rstart = wbyte[iap_pkg::CTRL0_RSTART_BIT] && wbyte[iap_pkg::CTRL0_RDEN_BIT];
        end
        iap_pkg::CTRL2_OFFSET: begin
          r_d.tsel = wbyte[iap_pkg::CTRL2_TSEL_BIT];
          r_d.clr  = wbyte[iap_pkg::CTRL2_CLEAR_BIT];
        end
        iap_pkg::ADDR_LOW_OFFSET: begin
          r_d.addr_lo = wbyte;
        end
        iap_pkg::ADDR_HIGH_OFFSET: begin
          r_d.addr_hi = wbyte[6:0];
        end
        iap_pkg::DATA0_LOW_OFFSET: begin
          if (r_q.ewen) begin
            r_d.data_lo = wbyte;
          end
        end
        iap_pkg::DATA0_HIGH_OFFSET: begin
          if (r_q.ewen) begin
            r_d.data_hi = wbyte;
            bport.load  = 1'b1;
            if (r_q.addr_lo[5:0] != iap_pkg::LAST_WORD) begin
              r_d.addr_lo = r_q.addr_lo + 8'h01;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // hardware set wins over a software clear in the same cycle
    if (unlock_ok && r_q.mode == iap_pkg::MODE_ENABLE) begin
      r_d.ewen = 1'b1;
    end

    // operation sequencer
    unique case (r_q.st)
      iap_pkg::ST_IDLE: begin
        r_d.timer = '0;
        if (r_q.clr) begin
          r_d.st = iap_pkg::ST_CLEAR;
        end else if (r_q.wstart && r_q.ewen && r_q.mode == iap_pkg::MODE_WRITE) begin
          r_d.st = iap_pkg::ST_WRITE;
          r_d.idx = '0;
          r_d.write_o = 1'b1;
        end else if (r_q.wstart && r_q.ewen && r_q.mode == iap_pkg::MODE_ERASE) begin
          r_d.st = iap_pkg::ST_ERASE;
          r_d.erase_o = 1'b1;
        end else if (r_q.wstart) begin
          r_d.wstart = 1'b0; // reserved or locked: no start
        end else if (r_q.rstart && r_q.rden && r_q.mode == iap_pkg::MODE_READ) begin
          r_d.st = iap_pkg::ST_READ_REQ;
        end else if (r_q.rstart) begin
          r_d.rstart = 1'b0;
        end
      end
      iap_pkg::ST_CLEAR: begin
        bport.clear = 1'b1;
        r_d.clr = 1'b0;
        r_d.st  = iap_pkg::ST_IDLE;
      end
      iap_pkg::ST_ERASE: begin
        r_d.erase_o = 1'b1;
        r_d.timer   = r_q.timer + 1'b1;
        if (r_q.timer == erase_cyc - 1'b1) begin
          r_d.erase_o = 1'b0;
          r_d.wstart  = 1'b0;
          r_d.st      = iap_pkg::ST_IDLE;
        end
      end
      iap_pkg::ST_WRITE: begin
        // one word per cycle streamed; program time counts from the first word
        r_d.write_o = 1'b1;
        r_d.timer   = r_q.timer + 1'b1;
        if (r_q.idx != iap_pkg::LAST_WORD) begin
          r_d.idx = r_q.idx + 6'h01;
        end
        if (r_q.timer == write_cyc - 1'b1) begin
          r_d.write_o = 1'b0;
          r_d.wstart  = 1'b0;
          bport.clear = 1'b1;
          r_d.st      = iap_pkg::ST_IDLE;
        end
      end
      iap_pkg::ST_READ_REQ: begin
        r_d.read_o = 1'b1;
        r_d.timer  = r_q.timer + 1'b1;
        if (r_q.timer == iap_pkg::TIMER_BITS'(iap_pkg::READ_CYC - 1)) begin
          r_d.st = iap_pkg::ST_READ_WAIT;
        end
      end
      iap_pkg::ST_READ_WAIT: begin
        r_d.read_o  = 1'b0;
        r_d.data_lo = flash_rdata[7:0];
        r_d.data_hi = flash_rdata[15:8];
        r_d.rstart  = 1'b0;
        r_d.st      = iap_pkg::ST_IDLE;
      end
      default: begin
        r_d.st = iap_pkg::ST_IDLE;
      end
    endcase

    // read data mux
    if (rd_acc) begin
      unique case (paddr)
        iap_pkg::CTRL0_OFFSET:      r_d.rdata = {24'h00_0000, r_q.ewen, r_q.mode, 1'b0, r_q.wstart, r_q.rden, r_q.rstart};
        iap_pkg::CTRL2_OFFSET:      r_d.rdata = {30'h0000_0000, r_q.tsel, r_q.clr};
        iap_pkg::ADDR_LOW_OFFSET:   r_d.rdata = {24'h00_0000, r_q.addr_lo};
        iap_pkg::ADDR_HIGH_OFFSET:  r_d.rdata = {25'h000_0000, r_q.addr_hi};
        iap_pkg::DATA0_LOW_OFFSET:  r_d.rdata = {24'h00_0000, r_q.data_lo};
        iap_pkg::DATA0_HIGH_OFFSET: r_d.rdata = {24'h00_0000, r_q.data_hi};
        default:                    r_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // single-cycle access phase; prdata decoded combinationally from paddr
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  always_comb begin
    unique case (paddr)
      iap_pkg::CTRL0_OFFSET:      prdata = {24'h00_0000, r_q.ewen, r_q.mode, 1'b0, r_q.wstart, r_q.rden, r_q.rstart};
      iap_pkg::CTRL2_OFFSET:      prdata = {30'h0000_0000, r_q.tsel, r_q.clr};
      iap_pkg::ADDR_LOW_OFFSET:   prdata = {24'h00_0000, r_q.addr_lo};
      iap_pkg::ADDR_HIGH_OFFSET:  prdata = {25'h000_0000, r_q.addr_hi};
      iap_pkg::DATA0_LOW_OFFSET:  prdata = {24'h00_0000, r_q.data_lo};
      iap_pkg::DATA0_HIGH_OFFSET: prdata = {24'h00_0000, r_q.data_hi};
      default:                    prdata = 32'h0000_0000;
    endcase
  end

  assign cpu_stall   = busy;
  assign flash_erase = r_q.erase_o;
  assign flash_write = r_q.write_o;
  assign flash_read  = r_q.read_o;
  assign flash_page  = {r_q.addr_hi, r_q.addr_lo[7:6]};
  assign flash_word  = (r_q.st == iap_pkg::ST_WRITE) ? r_q.idx : r_q.addr_lo[5:0];
  assign flash_wdata = bport.rd_word;

endmodule // iap_flash_page_writer

// >>> iap_flash_page_writer_sva.sv
// checker: port-level properties of the flash page writer
`timescale 1ns/1ps
module iap_flash_page_writer_sva #(
  parameter int ERASE_T0_CYC = iap_pkg::ERASE_T0_CYC,
  parameter int WRITE_T0_CYC = iap_pkg::WRITE_T0_CYC,
  parameter int ERASE_T1_CYC = iap_pkg::ERASE_T1_CYC,
  parameter int WRITE_T1_CYC = iap_pkg::WRITE_T1_CYC
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        cpu_stall,
  input wire logic        flash_erase,
  input wire logic        flash_write,
  input wire logic        flash_read,
  input wire logic [8:0]  flash_page
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // pulse length counters, too long for a repetition
  // ----------------------------------------------------------------
  int wr_cnt_q;
  int er_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_cnt_q <= 0;
      er_cnt_q <= 0;
    end else begin
      wr_cnt_q <= flash_write ? wr_cnt_q + 1 : 0;
      er_cnt_q <= flash_erase ? er_cnt_q + 1 : 0;
    end
  end

  property p_write_len;
    $fell(flash_write) |-> (wr_cnt_q == WRITE_T0_CYC || wr_cnt_q == WRITE_T1_CYC);
  endproperty
  a_write_len: assert property (p_write_len) else $error("write pulse length wrong");
  property p_erase_len;
    $fell(flash_erase) |-> (er_cnt_q == ERASE_T0_CYC || er_cnt_q == ERASE_T1_CYC);
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase pulse length wrong");
  property p_read_len;
    $rose(flash_read) |-> ##1 flash_read ##1 !flash_read;
  endproperty
  a_read_len: assert property (p_read_len) else $error("read request length wrong");
  property p_stall;
    (flash_write || flash_erase || flash_read) |-> cpu_stall;
  endproperty
  a_stall: assert property (p_stall) else $error("operation without stall");
  property p_one_op;
    $onehot0({flash_erase, flash_write, flash_read});
  endproperty
  a_one_op: assert property (p_one_op) else $error("two operations at once");
  property p_page_hold;
    flash_write ##1 flash_write |-> $stable(flash_page);
  endproperty
  a_page_hold: assert property (p_page_hold) else $error("page moved during write");
  property p_write_done;
    $fell(flash_write) |-> ##[1:3] !cpu_stall;
  endproperty
  a_write_done: assert property (p_write_done) else $error("stall kept after write");
  property p_clear;
    psel && penable && pwrite && paddr == iap_pkg::CTRL2_OFFSET && pwdata[0] && !cpu_stall
      |-> ##[1:3] cpu_stall ##[1:3] !cpu_stall;
  endproperty
  a_clear: assert property (p_clear) else $error("buffer clear did not run");
endmodule // iap_flash_page_writer_sva

bind iap_flash_page_writer iap_flash_page_writer_sva #(
  .ERASE_T0_CYC(ERASE_T0_CYC),
  .WRITE_T0_CYC(WRITE_T0_CYC),
  .ERASE_T1_CYC(ERASE_T1_CYC),
  .WRITE_T1_CYC(WRITE_T1_CYC)
) u_iap_flash_page_writer_sva (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .cpu_stall(cpu_stall), .flash_erase(flash_erase),
  .flash_write(flash_write), .flash_read(flash_read), .flash_page(flash_page));

// >>> iap_flash_page_writer_bench.sv
// testbench: apb register sequences against the flash page writer
`timescale 1ns/1ps
module iap_flash_page_writer_bench;
  localparam int ET0 = 100;
  localparam int WT0 = 80;
  localparam int ET1 = 120;
  localparam int WT1 = 90;
  logic        pclk, presetn, psel, penable, pwrite, unlock_ok;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, cpu_stall, flash_erase, flash_write, flash_read;
  logic [8:0]  flash_page;
  logic [5:0]  flash_word;
  logic [15:0] flash_wdata, flash_rdata, w62;
  int          mismatches, checks_done, act_cyc;

  iap_flash_page_writer #(.ERASE_T0_CYC(ET0), .WRITE_T0_CYC(WT0), .ERASE_T1_CYC(ET1),
    .WRITE_T1_CYC(WT1)) u_iap_flash_page_writer (.pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .cpu_stall(cpu_stall),
    .flash_erase(flash_erase), .flash_write(flash_write), .flash_read(flash_read),
    .flash_page(flash_page), .flash_word(flash_word), .flash_wdata(flash_wdata),
    .flash_rdata(flash_rdata), .unlock_ok(unlock_ok));

  // array word only meaningful during an operation; otherwise the inverse
  assign flash_rdata = cpu_stall ? 16'h5A3C : 16'hA5C3;

  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (flash_write || flash_erase) act_cyc++;
    if (flash_write && flash_word == 6'h3E) w62 = flash_wdata;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // entered just after a rising edge; request held until pready is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      report_and_stop();
    end
    rd = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
    chk(pslverr, 32'h0000_0000);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (3) @(posedge pclk);
    while (cpu_stall !== 1'b0 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 5000) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic run_op(input logic [31:0] c, input logic [31:0] cyc, input logic [15:0] w);
    act_cyc = 0;
    w62 = 16'h0;
    wr(iap_pkg::CTRL0_OFFSET, c);
    wait_idle();
    chk(act_cyc, cyc);
    chk(w62, w);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, unlock_ok} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    presetn = 0;
    mismatches = 0;
    checks_done = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rdc(iap_pkg::CTRL0_OFFSET, 32'h0);
    rdc(iap_pkg::CTRL2_OFFSET, 32'h0);
    wr(iap_pkg::ADDR_LOW_OFFSET, 32'h05);
    wr(iap_pkg::DATA0_LOW_OFFSET, 32'h34);
    wr(iap_pkg::DATA0_HIGH_OFFSET, 32'h12);
    rdc(iap_pkg::ADDR_LOW_OFFSET, 32'h05);
    wr(iap_pkg::CTRL0_OFFSET, 32'h80);
    rdc(iap_pkg::CTRL0_OFFSET, 32'h0);
    wr(iap_pkg::CTRL0_OFFSET, 32'h60);
    unlock_ok <= 1;
    repeat (2) @(posedge pclk);
    unlock_ok <= 0;
    rdc(iap_pkg::CTRL0_OFFSET, 32'hE0);
    wr(iap_pkg::ADDR_HIGH_OFFSET, 32'h7F);
    wr(iap_pkg::ADDR_LOW_OFFSET, 32'hFE);
    chk(flash_page, 32'h1FF);
    wr(iap_pkg::DATA0_LOW_OFFSET, 32'hCD);
    wr(iap_pkg::DATA0_HIGH_OFFSET, 32'hAB);
    rdc(iap_pkg::ADDR_LOW_OFFSET, 32'hFF);
    wr(iap_pkg::DATA0_HIGH_OFFSET, 32'hAB);
    rdc(iap_pkg::ADDR_LOW_OFFSET, 32'hFF);
    run_op(32'h84, WT0, 16'hABCD);
    rdc(iap_pkg::CTRL0_OFFSET, 32'h80);
    wr(iap_pkg::CTRL2_OFFSET, 32'h02);
    run_op(32'h84, WT1, 16'hFFFF);
    wr(iap_pkg::ADDR_LOW_OFFSET, 32'h3E);
    wr(iap_pkg::DATA0_LOW_OFFSET, 32'h11);
    wr(iap_pkg::DATA0_HIGH_OFFSET, 32'h22);
    wr(iap_pkg::CTRL2_OFFSET, 32'h03);
    wait_idle();
    rdc(iap_pkg::CTRL2_OFFSET, 32'h02);
    run_op(32'h84, WT1, 16'hFFFF);
    run_op(32'h94, ET1, 16'h0);
    run_op(32'hA4, 0, 16'h0);
    rdc(iap_pkg::CTRL0_OFFSET, 32'hA0);
    wr(iap_pkg::CTRL0_OFFSET, 32'h31);
    wait_idle();
    rdc(iap_pkg::CTRL0_OFFSET, 32'h30);
    rdc(iap_pkg::DATA0_LOW_OFFSET, 32'h11);
    wr(iap_pkg::CTRL0_OFFSET, 32'h33);
    wait_idle();
    rdc(iap_pkg::CTRL0_OFFSET, 32'h32);
    rdc(iap_pkg::DATA0_LOW_OFFSET, 32'h3C);
    rdc(iap_pkg::DATA0_HIGH_OFFSET, 32'h5A);
    wr(8'h1C, 32'hFF);
    rdc(8'h1C, 32'h0);
    report_and_stop();
  end
endmodule // iap_flash_page_writer_bench
